// ### rtl/usrx_pkg.sv
`default_nettype none
package usrx_pkg;
   // Register byte addresses on the APB bus.
   localparam logic [7:0] usrx_rx_status_control_addr = 8'h00;
   localparam logic [7:0] usrx_tx_status_control_addr = 8'h04;
   localparam logic [7:0] usrx_baud_divisor_addr      = 8'h08;
   localparam logic [7:0] usrx_rx_data_buffer_addr    = 8'h0c;
   localparam logic [7:0] usrx_irq_status_addr        = 8'h10;
   localparam logic [7:0] usrx_irq_mask_addr          = 8'h14;
   // Field positions in the receive status and control register.
   localparam int usrx_port_on_bit          = 7;
   localparam int usrx_nine_bit_rx_sel_bit  = 6;
   localparam int usrx_single_rx_on_bit     = 5;
   localparam int usrx_continuous_rx_on_bit = 4;
   localparam int usrx_addr_detect_on_bit   = 3;
   localparam int usrx_framing_err_bit      = 2;
   localparam int usrx_overrun_err_bit      = 1;
   localparam int usrx_rx_ninth_bit_bit     = 0;
   // Field positions in the transmit status and control register.
   localparam int usrx_clock_master_bit     = 7;
   localparam int usrx_sync_mode_bit        = 4;
   localparam int usrx_high_speed_sel_bit   = 2;
   // Interrupt status bits.
   localparam int usrx_irq_rx_bit           = 0;
   localparam int usrx_irq_framing_bit      = 1;
   localparam int usrx_irq_overrun_bit      = 2;
   // Reset values.
   localparam logic [7:0] usrx_rx_status_control_reset = 8'h00;
   localparam logic [7:0] usrx_tx_status_control_reset = 8'h00;
   localparam logic [7:0] usrx_baud_divisor_reset      = 8'h00;
   // Prescale ratios: asynchronous low speed, high speed and synchronous.
   localparam logic [5:0] usrx_prescale_async_low  = 6'h3f;
   localparam logic [5:0] usrx_prescale_async_high = 6'h0f;
   localparam logic [5:0] usrx_prescale_sync       = 6'h03;

   typedef struct packed {
      logic [8:0] data;
      logic       stop_ok;
   } usrx_char_s;

   typedef struct packed {
      logic       sync_mode;
      logic       clock_master;
      logic       high_speed_sel;
      logic [7:0] baud_divisor;
   } usrx_baud_cfg_s;
endpackage
`default_nettype wire

// ### rtl/usrx_baud_gen.sv
`default_nettype none
module usrx_baud_gen
   import usrx_pkg::*;
(
   // Clock and reset.
   input  wire logic           clock,
   input  wire logic           rstn,
   // Configuration.
   input  wire usrx_baud_cfg_s cfg,
   input  wire logic           divisor_write,
   // Rate output.
   output logic                baud_tick
);
   logic [5:0] prescale;
   logic [5:0] next_prescale;
   logic [7:0] timer;
   logic [7:0] next_timer;
   logic       next_baud_tick;
   logic [5:0] ratio;

   always_comb begin
      if (cfg.sync_mode) begin
         ratio = usrx_prescale_sync; // see RULE_13
      end else if (cfg.high_speed_sel) begin
         ratio = usrx_prescale_async_high; // see RULE_12
      end else begin
         ratio = usrx_prescale_async_low;
      end
      next_prescale  = prescale;
      next_timer     = timer;
      next_baud_tick = 1'b0;
      if (divisor_write) begin
         // Restarting at once means the new rate shows without a stale period.
         next_prescale = 6'h00; // see RULE_17
         next_timer    = 8'h00;
      end else if (prescale >= ratio) begin
         next_prescale = 6'h00;
         if (timer >= cfg.baud_divisor) begin
            next_timer = 8'h00; // see RULE_11
            // Slave mode takes its clock from outside, so no tick is made.
            next_baud_tick = !cfg.sync_mode || cfg.clock_master; // see RULE_14
         end else begin
            next_timer = timer + 8'h01;
         end
      end else begin
         next_prescale = prescale + 6'h01; // see RULE_15
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         prescale  <= 6'h00;
         timer     <= 8'h00;
         baud_tick <= 1'b0;
      end else begin
         prescale  <= next_prescale;
         timer     <= next_timer;
         baud_tick <= next_baud_tick;
      end
   end
endmodule
`default_nettype wire

// ### rtl/usrx_sync2.sv
`default_nettype none
module usrx_sync2 (
   // Clock and reset.
   input  wire logic clock,
   input  wire logic rstn,
   // Data.
   input  wire logic d,
   output logic      q
);
   logic meta;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta <= 1'b1;
         q    <= 1'b1;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

// ### rtl/usrx_top.sv
// Operation
// RULE_01 - The port enable bit must be set before the serial pins act as serial pins.
// RULE_02 - The nine-bit select picks nine data bits per character, else eight.
// RULE_03 - In nine-bit async address mode only characters with the ninth bit set are kept.
// RULE_04 - Without address detection every character is kept; the ninth bit may be parity.
// RULE_05 - In sync master mode single receive starts one reception and then clears itself.
// RULE_06 - In sync mode continuous receive runs until cleared and overrides single receive.
// RULE_07 - In asynchronous mode continuous receive turns the receiver on while set.
// RULE_08 - The framing flag marks a bad stop bit and follows the next character after a read.
// RULE_09 - The overrun flag is set on overrun and cleared when continuous receive is cleared.
// RULE_10 - One dedicated 8-bit rate generator serves both modes.
// RULE_11 - The generator is a free-running 8-bit timer whose period is set by the divisor.
// RULE_12 - In asynchronous mode the high-speed select also sets the rate.
// RULE_13 - In synchronous mode the high-speed select is ignored.
// RULE_14 - The divisor-derived rate applies only when the device makes the clock.
// RULE_15 - The rate is the clock over divisor plus one times 64, 16 or 4 by mode.
// RULE_16 - Software may prefer high speed even for slow rates to cut rate error.
// RULE_17 - Any divisor write resets the rate timer at once.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`default_nettype none
module usrx_top
   import usrx_pkg::*;
(
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rstn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial line.
   input  wire logic        rx_pin,
   output logic             port_on_out,
   output logic             baud_tick_out,
   output logic             sample_clock_out,
   // Interrupt.
   output logic             irq
);
   logic [7:0]     rx_status_control;
   logic [7:0]     next_rx_status_control;
   logic [7:0]     tx_status_control;
   logic [7:0]     next_tx_status_control;
   logic [7:0]     baud_divisor;
   logic [7:0]     next_baud_divisor;
   logic [7:0]     rx_data_buffer;
   logic [7:0]     next_rx_data_buffer;
   logic           buffer_full;
   logic           next_buffer_full;
   logic           data_was_read;
   logic           next_data_was_read;
   logic [2:0]     irq_status;
   logic [2:0]     next_irq_status;
   logic [2:0]     irq_mask;
   logic [2:0]     next_irq_mask;
   logic [31:0]    next_prdata;
   logic           next_pready;
   logic           next_pslverr;
   logic           rx_sync;
   logic           baud_tick;
   usrx_baud_cfg_s baud_cfg;

   typedef enum logic [1:0] {usrx_idle, usrx_bits, usrx_stop} usrx_state_e;
   usrx_state_e    state;
   usrx_state_e    next_state;
   logic [3:0]     bit_count;
   logic [3:0]     next_bit_count;
   logic [8:0]     shift;
   logic [8:0]     next_shift;
   logic           next_sample_clock;

   logic port_on;
   logic nine_bit_rx_sel;
   logic single_rx_on;
   logic continuous_rx_on;
   logic addr_detect_on;
   logic sync_mode;
   logic clock_master;
   logic rx_active;
   logic access;
   logic wr;
   logic rd;
   usrx_char_s rx_char;
   logic char_done;

   assign port_on          = rx_status_control[usrx_port_on_bit];
   assign nine_bit_rx_sel  = rx_status_control[usrx_nine_bit_rx_sel_bit];
   assign single_rx_on     = rx_status_control[usrx_single_rx_on_bit];
   assign continuous_rx_on = rx_status_control[usrx_continuous_rx_on_bit];
   assign addr_detect_on   = rx_status_control[usrx_addr_detect_on_bit];
   assign sync_mode        = tx_status_control[usrx_sync_mode_bit];
   assign clock_master     = tx_status_control[usrx_clock_master_bit];
   assign access           = psel && penable && pready;
   assign wr               = access && pwrite;
   assign rd               = access && !pwrite;

   // Single receive counts only in synchronous master mode; continuous wins.
   assign rx_active = port_on && (continuous_rx_on // see RULE_01 see RULE_06 see RULE_07
                      || (sync_mode && clock_master && single_rx_on)); // see RULE_05

   assign baud_cfg.sync_mode      = sync_mode;
   assign baud_cfg.clock_master   = clock_master;
   assign baud_cfg.high_speed_sel = tx_status_control[usrx_high_speed_sel_bit];
   assign baud_cfg.baud_divisor   = baud_divisor;

   usrx_sync2 u_rx_sync (
      .clock (clock),
      .rstn  (rstn),
      .d     (rx_pin),
      .q     (rx_sync)
   );

   // One generator serves both modes.
   usrx_baud_gen u_baud_gen ( // see RULE_10
      .clock         (clock),
      .rstn          (rstn),
      .cfg           (baud_cfg),
      .divisor_write (wr && paddr == usrx_baud_divisor_addr),
      .baud_tick     (baud_tick)
   );

   // Each tick samples one bit; the sampling circuit is simplified to one sample per bit.
   always_comb begin
      next_state        = state;
      next_bit_count    = bit_count;
      next_shift        = shift;
      next_sample_clock = 1'b0;
      char_done         = 1'b0;
      rx_char.data      = shift;
      rx_char.stop_ok   = 1'b1;
      if (!rx_active) begin
         next_state = usrx_idle;
      end else if (baud_tick) begin
         next_sample_clock = sync_mode;
         unique case (state)
            usrx_idle: begin
               // With one sample per bit the next tick already falls in the first data bit,
               // so a low line on a tick is taken as the start bit without a second look.
               if (sync_mode || !rx_sync) begin
                  next_state     = usrx_bits;
                  next_bit_count = 4'h0;
                  if (sync_mode) begin
                     next_shift = {rx_sync, shift[8:1]};
                     next_bit_count = 4'h1;
                  end
               end
            end
            usrx_bits: begin
               next_shift     = {rx_sync, shift[8:1]};
               next_bit_count = bit_count + 4'h1;
               if (bit_count == (nine_bit_rx_sel ? 4'h8 : 4'h7)) begin // see RULE_02
                  next_state = sync_mode ? usrx_idle : usrx_stop;
                  if (sync_mode) begin
                     char_done = 1'b1;
                     rx_char.data = nine_bit_rx_sel ? {rx_sync, shift[8:1]}
                                                    : {1'b0, rx_sync, shift[8:2]};
                  end
               end
            end
            usrx_stop: begin
               next_state      = usrx_idle;
               char_done       = 1'b1;
               rx_char.data    = nine_bit_rx_sel ? shift : {1'b0, shift[8:1]};
               rx_char.stop_ok = rx_sync;
            end
            default: next_state = usrx_idle;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state            <= usrx_idle;
         bit_count        <= 4'h0;
         shift            <= 9'h000;
         sample_clock_out <= 1'b0;
      end else begin
         state            <= next_state;
         bit_count        <= next_bit_count;
         shift            <= next_shift;
         sample_clock_out <= next_sample_clock;
      end
   end

   always_comb begin
      next_rx_status_control = rx_status_control;
      next_tx_status_control = tx_status_control;
      next_baud_divisor      = baud_divisor;
      next_rx_data_buffer    = rx_data_buffer;
      next_buffer_full       = buffer_full;
      next_data_was_read     = data_was_read;
      next_irq_mask          = irq_mask;
      next_irq_status        = irq_status;
      if (wr) begin
         unique case (paddr)
            usrx_rx_status_control_addr: begin
               next_rx_status_control[7:3] = pwdata[7:3];
               // Clearing continuous receive also clears the overrun flag.
               if (!pwdata[usrx_continuous_rx_on_bit]) begin
                  next_rx_status_control[usrx_overrun_err_bit] = 1'b0; // see RULE_09
               end
            end
            usrx_tx_status_control_addr: next_tx_status_control = {pwdata[7:4], 1'b0,
                                                                   pwdata[2], 2'b00};
            usrx_baud_divisor_addr: next_baud_divisor = pwdata[7:0];
            usrx_irq_status_addr:   next_irq_status   = irq_status & ~pwdata[2:0];
            usrx_irq_mask_addr:     next_irq_mask     = pwdata[2:0];
            default: ;
         endcase
      end
      if (rd && paddr == usrx_rx_data_buffer_addr) begin
         next_buffer_full   = 1'b0;
         next_data_was_read = 1'b1;
      end
      if (char_done) begin
         if (sync_mode && !continuous_rx_on) begin
            next_rx_status_control[usrx_single_rx_on_bit] = 1'b0; // see RULE_05
         end
         if (buffer_full) begin
            next_rx_status_control[usrx_overrun_err_bit] = 1'b1; // see RULE_09
            next_irq_status[usrx_irq_overrun_bit] = 1'b1;
         end else if (sync_mode || !nine_bit_rx_sel || !addr_detect_on // see RULE_04
                      || rx_char.data[8]) begin // see RULE_03
            next_rx_data_buffer = rx_char.data[7:0];
            next_rx_status_control[usrx_rx_ninth_bit_bit] = rx_char.data[8];
            next_buffer_full = 1'b1;
            next_irq_status[usrx_irq_rx_bit] = 1'b1;
            // The flag follows a new character once the old one was read, and at once on a bad stop bit.
            if (data_was_read || !rx_char.stop_ok) begin
               next_rx_status_control[usrx_framing_err_bit] = !rx_char.stop_ok; // see RULE_08
               next_data_was_read = 1'b0;
            end
            if (!rx_char.stop_ok) begin
               next_irq_status[usrx_irq_framing_bit] = 1'b1;
            end
         end
      end
   end

   always_comb begin
      next_pready  = psel && !pready;
      next_pslverr = 1'b0;
      next_prdata  = 32'h0000_0000;
      if (psel && !pready && !pwrite) begin
         unique case (paddr)
            usrx_rx_status_control_addr: next_prdata = {24'h000000, rx_status_control};
            usrx_tx_status_control_addr: next_prdata = {24'h000000, tx_status_control};
            usrx_baud_divisor_addr:      next_prdata = {24'h000000, baud_divisor};
            usrx_rx_data_buffer_addr:    next_prdata = {24'h000000, rx_data_buffer};
            usrx_irq_status_addr:        next_prdata = {29'h00000000, irq_status};
            usrx_irq_mask_addr:          next_prdata = {29'h00000000, irq_mask};
            default:                     next_pslverr = 1'b1;
         endcase
      end else if (psel && !pready) begin
         next_pslverr = !(paddr == usrx_rx_status_control_addr
                       || paddr == usrx_tx_status_control_addr
                       || paddr == usrx_baud_divisor_addr
                       || paddr == usrx_irq_status_addr
                       || paddr == usrx_irq_mask_addr);
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rx_status_control <= usrx_rx_status_control_reset;
         tx_status_control <= usrx_tx_status_control_reset;
         baud_divisor      <= usrx_baud_divisor_reset;
         rx_data_buffer    <= 8'h00;
         buffer_full       <= 1'b0;
         data_was_read     <= 1'b1;
         irq_status        <= 3'h0;
         irq_mask          <= 3'h0;
         prdata            <= 32'h0000_0000;
         pready            <= 1'b0;
         pslverr           <= 1'b0;
         irq               <= 1'b0;
         port_on_out       <= 1'b0;
         baud_tick_out     <= 1'b0;
      end else begin
         rx_status_control <= next_rx_status_control;
         tx_status_control <= next_tx_status_control;
         baud_divisor      <= next_baud_divisor;
         rx_data_buffer    <= next_rx_data_buffer;
         buffer_full       <= next_buffer_full;
         data_was_read     <= next_data_was_read;
         irq_status        <= next_irq_status;
         irq_mask          <= next_irq_mask;
         prdata            <= next_prdata;
         pready            <= next_pready;
         pslverr           <= next_pslverr;
         irq               <= |(next_irq_status & next_irq_mask);
         port_on_out       <= port_on; // see RULE_01
         baud_tick_out     <= baud_tick;
      end
   end
endmodule
`default_nettype wire

// ### verification/usrx_rx_monitor.sv
`default_nettype none
module usrx_rx_monitor (
   // Clock and reset.
   input wire logic        clock,
   input wire logic        rstn,
   // APB slave side.
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Serial side and interrupt.
   input wire logic        rx_pin,
   input wire logic        port_on_out,
   input wire logic        baud_tick_out,
   input wire logic        sample_clock_out,
   input wire logic        irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   logic mapped;
   logic wr_done;
   assign mapped  = paddr <= 8'h14 && paddr[1:0] == 2'h0;
   assign wr_done = pready && pwrite && !pslverr;

   AST_READY_TIME: assert property (psel && !penable |=> pready)
      else $error("ready late");
   AST_READY_IDLE: assert property (!psel |=> !pready)
      else $error("ready without access");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready held");
   AST_ERR_UNMAPPED: assert property (pready && !mapped |-> pslverr)
      else $error("unmapped access accepted");
   AST_ERR_MAPPED: assert property (pready && mapped && !(pwrite && paddr == 8'h0c) |-> !pslverr)
      else $error("mapped access refused");
   AST_RESERVED_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("reserved bits set");
   AST_TICK_GAP: assert property (baud_tick_out |=> !baud_tick_out [*3])
      else $error("rate ticks too close");
   // Three cycles of slack let the registered pin copy and the sampler settle.
   AST_PORT_GATE: assert property (!port_on_out [*3] |-> !sample_clock_out)
      else $error("sampling while port off");
   AST_PORT_ON: assert property (
      wr_done && paddr == 8'h00 && pwdata[7] |-> ##[1:2] port_on_out)
      else $error("port enable not applied");
   AST_IRQ_MASKED: assert property (
      wr_done && paddr == 8'h14 && pwdata[2:0] == 3'h0 |-> ##[1:2] !irq)
      else $error("masked interrupt stays high");

   cover property (pready && pslverr);
   cover property (irq);
   cover property (sample_clock_out);
endmodule
bind usrx_top usrx_rx_monitor mon (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rx_pin(rx_pin), .port_on_out(port_on_out),
   .baud_tick_out(baud_tick_out), .sample_clock_out(sample_clock_out), .irq(irq));
`default_nettype wire

// ### verification/usrx_remote_tx.sv
`default_nettype none
module usrx_remote_tx (
   // Clock and device strobes.
   input  wire logic clock,
   input  wire logic baud_tick,
   input  wire logic sample_clock,
   // Serial line.
   output var logic  line
);
   timeunit 1ns;
   timeprecision 1ns;
   initial line = 1'b1;
   // Launching just after a tick gives the device a whole bit period to sample.
   task automatic tick_wait();
      do @(negedge clock); while (baud_tick !== 1'b1);
      @(posedge clock);
   endtask
   task automatic send(input logic [8:0] d, input int n, input logic stop_ok);
      tick_wait();
      line <= 1'b0;
      for (int i = 0; i < n; i++) begin
         tick_wait();
         line <= d[i];
      end
      tick_wait();
      line <= stop_ok;
      tick_wait();
      line <= 1'b1;
   endtask
   // The last bit is not held past its sample: the line then shows its inverse.
   task automatic send_sync(input logic [7:0] d);
      line <= d[0];
      for (int i = 1; i < 9; i++) begin
         do @(negedge clock); while (sample_clock !== 1'b1);
         @(posedge clock);
         line <= (i < 8) ? d[i] : ~d[7];
      end
   endtask
endmodule
`default_nettype wire

// ### verification/serial_rx_control_and_baud_gen_test.sv
`default_nettype none
module serial_rx_control_and_baud_gen_test import usrx_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock   = 1'b0;
   logic        rstn    = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata, r;
   logic        pready, pslverr, rx_pin, port_on_out, baud_tick_out, sample_clock_out, irq, e;
   int          error_cnt = 0;
   int          num_checks = 0;
   int          cyc = 0;
   usrx_top uut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_pin(rx_pin), .port_on_out(port_on_out), .baud_tick_out(baud_tick_out),
      .sample_clock_out(sample_clock_out), .irq(irq));
   usrx_remote_tx peer (.clock(clock), .baud_tick(baud_tick_out),
      .sample_clock(sample_clock_out), .line(rx_pin));
   initial forever #5 clock = ~clock;
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // Pready and the read data are taken at the rising edge that ends the access.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic gap(output int n, output int g);
      n = 0;
      g = 0;
      // Ticks still in the output pipeline belong to the old setting.
      repeat (2) @(negedge clock);
      do @(negedge clock); while (baud_tick_out !== 1'b1 && ++n < 1100);
      if (n < 1100) begin
         do begin
            @(negedge clock);
            g++;
         end while (baud_tick_out !== 1'b1 && g < 300);
      end
   endtask
   task automatic t_regs();
      bus(0, usrx_rx_status_control_addr, 0);
      check(r, 32'h0);
      bus(1, usrx_rx_status_control_addr, 32'hff);
      bus(0, usrx_rx_status_control_addr, 0);
      check(r, 32'hf8);
      bus(1, usrx_tx_status_control_addr, 32'hff);
      bus(0, usrx_tx_status_control_addr, 0);
      check(r, 32'hf4);
      bus(1, usrx_baud_divisor_addr, 32'ha5);
      bus(0, usrx_baud_divisor_addr, 0);
      check(r, 32'ha5);
      bus(0, 8'h18, 0);
      check(32'(e), 32'h1);
      bus(1, usrx_rx_data_buffer_addr, 32'h1);
      check(32'(e), 32'h1);
      bus(1, usrx_rx_status_control_addr, 32'h0);
   endtask
   task automatic t_baud();
      logic [7:0] m [5] = '{8'h00, 8'h04, 8'h90, 8'h94, 8'h10};
      int x [5] = '{192, 48, 12, 12, 0};
      int n, g;
      bus(1, usrx_rx_status_control_addr, 32'h80);
      bus(1, usrx_baud_divisor_addr, 32'h2);
      foreach (m[i]) begin
         bus(1, usrx_tx_status_control_addr, {24'h0, m[i]});
         gap(n, g);
         check(g, x[i]);
      end
      bus(1, usrx_tx_status_control_addr, 32'h04);
      bus(1, usrx_baud_divisor_addr, 32'hff);
      idle(200);
      bus(1, usrx_baud_divisor_addr, 32'h0);
      gap(n, g);
      check(32'(n <= 20), 32'h1);
      check(g, 16);
   endtask
   task automatic t_rx();
      bus(1, usrx_irq_mask_addr, 32'h1);
      bus(1, usrx_rx_status_control_addr, 32'h90);
      peer.send(9'h0a5, 8, 1'b1);
      idle(64);
      check(32'(irq), 32'h1);
      bus(0, usrx_rx_data_buffer_addr, 0);
      check(r, 32'ha5);
      bus(1, usrx_irq_status_addr, 32'h7);
      idle(3);
      check(32'(irq), 32'h0);
      bus(1, usrx_irq_mask_addr, 32'h0);
      bus(1, usrx_rx_status_control_addr, 32'h80);
      peer.send(9'h011, 8, 1'b1);
      idle(64);
      bus(0, usrx_irq_status_addr, 0);
      check(r, 32'h0);
   endtask
   task automatic t_addr();
      bus(1, usrx_rx_status_control_addr, 32'hd8);
      peer.send(9'h033, 9, 1'b1);
      idle(64);
      bus(0, usrx_irq_status_addr, 0);
      check(r, 32'h0);
      peer.send(9'h15c, 9, 1'b1);
      idle(64);
      bus(0, usrx_rx_status_control_addr, 0);
      check(r, 32'hd9);
      bus(0, usrx_rx_data_buffer_addr, 0);
      check(r, 32'h5c);
      bus(1, usrx_rx_status_control_addr, 32'hd0);
      peer.send(9'h011, 9, 1'b1);
      idle(64);
      bus(0, usrx_rx_status_control_addr, 0);
      check(r, 32'hd0);
      bus(0, usrx_rx_data_buffer_addr, 0);
      check(r, 32'h11);
   endtask
   task automatic t_err();
      bus(1, usrx_rx_status_control_addr, 32'h90);
      peer.send(9'h055, 8, 1'b0);
      idle(64);
      bus(0, usrx_rx_status_control_addr, 0);
      check(r, 32'h94);
      bus(0, usrx_rx_data_buffer_addr, 0);
      peer.send(9'h066, 8, 1'b1);
      idle(64);
      bus(0, usrx_rx_status_control_addr, 0);
      check(r, 32'h90);
      bus(0, usrx_rx_data_buffer_addr, 0);
      check(r, 32'h66);
      bus(1, usrx_irq_status_addr, 32'h7);
      peer.send(9'h001, 8, 1'b1);
      peer.send(9'h002, 8, 1'b1);
      idle(64);
      bus(0, usrx_rx_status_control_addr, 0);
      check(r, 32'h92);
      bus(0, usrx_irq_status_addr, 0);
      check(r, 32'h5);
      bus(1, usrx_rx_status_control_addr, 32'h80);
      bus(0, usrx_rx_status_control_addr, 0);
      check(r, 32'h80);
      bus(0, usrx_rx_data_buffer_addr, 0);
      check(r, 32'h01);
   endtask
   task automatic t_sync();
      bus(1, usrx_tx_status_control_addr, 32'h90);
      fork
         peer.send_sync(8'h96);
         bus(1, usrx_rx_status_control_addr, 32'ha0);
      join
      idle(8);
      bus(0, usrx_rx_status_control_addr, 0);
      check(r, 32'h80);
      bus(0, usrx_rx_data_buffer_addr, 0);
      check(r, 32'h96);
      fork
         peer.send_sync(8'h3a);
         bus(1, usrx_rx_status_control_addr, 32'hb0);
      join
      bus(0, usrx_rx_status_control_addr, 0);
      check(r, 32'hb0);
      bus(1, usrx_rx_status_control_addr, 32'h80);
      bus(0, usrx_rx_data_buffer_addr, 0);
      check(r, 32'h3a);
   endtask
   initial begin
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      t_regs();
      t_baud();
      t_rx();
      t_addr();
      t_err();
      t_sync();
      complete_run();
   end
endmodule
`default_nettype wire
